/* src/mam_regs.svh */
// Register offsets, field positions, reset values and counts of the management port.
// Assumes inclusion by src/mam_mgmt.sv only.
`ifndef MAM_REGS_SVH
`define MAM_REGS_SVH
`define MAM_REG_CTRL    5'h00
`define MAM_REG_STAT    5'h01
`define MAM_REG_ADV     5'h04
`define MAM_REG_LP      5'h05
`define MAM_REG_EXP     5'h06
`define MAM_REG_SUM     5'h10
`define MAM_PHY_ADDR    5'h01
`define MAM_PRE_LAST    6'h1F
`define MAM_LAST_BIT    4'hF
`define MAM_ADDR_LAST   4'h4
`define MAM_STRAP_CYC   2'h3
`define MAM_STAT_CONST  16'h7849
`define MAM_LP_PD100    16'h0081
`define MAM_LP_PD10     16'h0021
`define MAM_ADV_SEL     5'h01
`define MAM_CTL_SPEED   13
`define MAM_CTL_NEGEN   12
`define MAM_CTL_RESTART 9
`define MAM_CTL_DUPLEX  8
`endif

/* src/mam_pkg.sv */
// Types shared by the management port modules.
// Assumes nothing of its surroundings.
package mam_pkg;
  typedef enum logic [2:0] {
    S_PRE, S_IDLE, S_ST, S_OP, S_PHY, S_REG, S_TA, S_DAT
  } mam_st_t;

  typedef struct packed {
    logic       mdc_s1, mdc_s2, mdc_d, dio_s1, dio_s2;
    logic [2:0] strap_s1, strap_s2;
    logic [1:0] init_cnt;
    mam_st_t    st;
    logic [3:0] cnt;
    logic [5:0] ones;
    logic       op_b, rd;
    logic [4:0] phy, ra;
    logic [15:0] sh;
    logic       dio_o, dio_oe;
    logic       spd_c, negen_c, dpx_c;
    logic [15:0] adv, lp;
    logic       done, lp_able, pd_fault, restart;
    logic       spd_o, dpx_o;
  } mam_state_t;

  typedef struct packed {
    logic spd100, fdx, none;
  } mam_res_t;
endpackage

/* src/mam_resolve.sv */
// Priority resolution of the highest common technology.
// Assumes ability nibbles ordered 100FD, 100HD, 10FD, 10HD from the top.
`timescale 1ns/1ps
`default_nettype none
module mam_resolve
  import mam_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Ability nibbles.
  input  wire logic [3:0] adv_i,
  input  wire logic [3:0] lp_i,
  // Result.
  output logic            spd100_o,
  output logic            fdx_o,
  output logic            none_o
);
  mam_res_t   res_ff, nxt_res;
  logic [3:0] c;

  always_comb begin
    c = adv_i & lp_i;
    nxt_res.spd100 = c[3] | c[2];
    nxt_res.fdx    = c[3] | (~c[2] & c[1]);
    nxt_res.none   = ~|c;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      res_ff <= '0;
    end else begin
      res_ff <= nxt_res;
    end
  end

  assign spd100_o = res_ff.spd100;
  assign fdx_o    = res_ff.fdx;
  assign none_o   = res_ff.none;

  a_prio_top: assert property (@(posedge clk_i) disable iff (srst_i)
    (adv_i[3] && lp_i[3]) |=> (spd100_o && fdx_o))
    else $error("Common 100FD not chosen.");
endmodule
`default_nettype wire

/* src/mam_mgmt.sv */
// Management port of the transceiver with negotiation control and status.
// Assumes MDC and MDIO arrive asynchronously; negotiation events come from same-clock logic.
// Notes on behaviour
// - Shared data line, up to 32 addressed devices.
// - Ignore frames until preamble seen once.
// - Bad start, opcode or turnaround drops sync.
// - Frame starts with zero then one.
// - Read: release first turnaround, drive zero, data.
// - Fixed field order, most significant bit first.
// - Preamble suppression supported, status bit 6 set.
// - Straps load advertisement bits 8 to 5.
// - Negotiation strap low forces strapped mode.
// - Negotiation strap high selects advertised set.
// - Control writes override strapped mode later.
// - Advertisement register is sent during negotiation.
// - Resolve highest common mode by priority.
// - Forced speed and duplex only without negotiation.
// - Status ability bits constant, T4 zero.
// - Advertise all only with all straps high, software may clear.
// - Partner register holds pages or detect pattern.
// - Parallel detect: complete set, partner-able clear.
// - Not exactly one link sets detect fault.
// - Thirty-two sixteen-bit management registers.
// - Control bit 9 restarts negotiation.
`timescale 1ns/1ps
`default_nettype none
`include "mam_regs.svh"
module mam_mgmt
  import mam_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Management pins.
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  // Straps.
  input  wire logic        negotiation_enable_strap_i,
  input  wire logic        mode_strap_high_i,
  input  wire logic        mode_strap_low_i,
  // Negotiation engine.
  input  wire logic        link_up_i,
  input  wire logic        neg_page_rx_i,
  input  wire logic [15:0] neg_page_i,
  input  wire logic        pd_event_i,
  input  wire logic        pd_link10_i,
  input  wire logic        pd_link100_i,
  // Operating mode.
  output logic [15:0]      adv_word_o,
  output logic             neg_enable_o,
  output logic             neg_restart_o,
  output logic             neg_complete_o,
  output logic             speed100_o,
  output logic             full_dpx_o
);
  mam_state_t r_ff, nxt_r;
  logic res_spd, res_fdx;
  logic rise, bitv, hit;
  logic [15:0] d;

  // ==========================================================
  // Decoding
  function automatic logic [3:0] strap_adv(input logic [2:0] s);
    case (s)
      3'h0:    strap_adv = 4'h1;
      3'h1:    strap_adv = 4'h2;
      3'h2:    strap_adv = 4'h4;
      3'h3:    strap_adv = 4'h8;
      3'h4:    strap_adv = 4'h3;
      3'h5:    strap_adv = 4'hC;
      3'h6:    strap_adv = 4'h5;
      default: strap_adv = 4'hF;
    endcase
  endfunction

  function automatic logic [15:0] rd_word(input logic [4:0] a,
                                          input mam_state_t s,
                                          input logic lnk);
    case (a)
      `MAM_REG_CTRL: rd_word = {2'h0, s.spd_c, s.negen_c, 3'h0, s.dpx_c, 8'h00};
      `MAM_REG_STAT: rd_word = `MAM_STAT_CONST
                               | {10'h000, s.done, s.lp[13], 1'b0, lnk, 2'h0};
      `MAM_REG_ADV:  rd_word = s.adv;
      `MAM_REG_LP:   rd_word = s.lp;
      `MAM_REG_EXP:  rd_word = {11'h000, s.pd_fault, 3'h0, s.lp_able};
      `MAM_REG_SUM:  rd_word = {11'h000, s.done, 1'b0, s.dpx_o, ~s.spd_o, lnk};
      default:       rd_word = 16'h0000;
    endcase
  endfunction

  mam_resolve u_res (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .adv_i   (r_ff.adv[8:5]),
    .lp_i    (r_ff.lp[8:5]),
    .spd100_o(res_spd),
    .fdx_o   (res_fdx),
    .none_o  ()
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.mdc_s1   = mdc_i;
    nxt_r.mdc_s2   = r_ff.mdc_s1;
    nxt_r.mdc_d    = r_ff.mdc_s2;
    nxt_r.dio_s1   = mdio_i;
    nxt_r.dio_s2   = r_ff.dio_s1;
    nxt_r.strap_s1 = {negotiation_enable_strap_i, mode_strap_high_i, mode_strap_low_i};
    nxt_r.strap_s2 = r_ff.strap_s1;
    nxt_r.restart  = 1'b0;
    rise = r_ff.mdc_s2 & ~r_ff.mdc_d;
    bitv = r_ff.dio_s2;
    hit  = (r_ff.phy == `MAM_PHY_ADDR);
    d    = {r_ff.sh[14:0], bitv};

    // Straps are read only once the synchronisers hold settled levels.
    if (r_ff.init_cnt != `MAM_STRAP_CYC) begin
      nxt_r.init_cnt = r_ff.init_cnt + 2'h1;
      if (r_ff.init_cnt == `MAM_STRAP_CYC - 2'h1) begin
        nxt_r.negen_c = r_ff.strap_s2[2];
        nxt_r.spd_c   = r_ff.strap_s2[1];
        nxt_r.dpx_c   = r_ff.strap_s2[0];
        nxt_r.adv     = {7'h00, strap_adv(r_ff.strap_s2), `MAM_ADV_SEL};
      end
    end

    if (rise) begin
      case (r_ff.st)
        S_PRE: begin
          if (!bitv) begin
            nxt_r.ones = 6'h00;
          end else if (r_ff.ones == `MAM_PRE_LAST) begin
            nxt_r.st = S_IDLE;
          end else begin
            nxt_r.ones = r_ff.ones + 6'h01;
          end
        end
        S_IDLE: begin
          // No preamble is needed from here on.
          if (!bitv) begin
            nxt_r.st = S_ST;
          end
        end
        S_ST: begin
          nxt_r.cnt = 4'h0;
          nxt_r.st  = bitv ? S_OP : S_PRE;
          nxt_r.ones = 6'h00;
        end
        S_OP: begin
          if (r_ff.cnt == 4'h0) begin
            nxt_r.op_b = bitv;
            nxt_r.cnt  = 4'h1;
          end else if (r_ff.op_b != bitv) begin
            nxt_r.rd  = r_ff.op_b;
            nxt_r.cnt = 4'h0;
            nxt_r.st  = S_PHY;
          end else begin
            nxt_r.st = S_PRE;
          end
        end
        S_PHY: begin
          nxt_r.phy = {r_ff.phy[3:0], bitv};
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt == `MAM_ADDR_LAST) begin
            nxt_r.cnt = 4'h0;
            nxt_r.st  = S_REG;
          end
        end
        S_REG: begin
          nxt_r.ra  = {r_ff.ra[3:0], bitv};
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.cnt == `MAM_ADDR_LAST) begin
            nxt_r.cnt = 4'h0;
            nxt_r.st  = S_TA;
            nxt_r.sh  = rd_word({r_ff.ra[3:0], bitv}, r_ff, link_up_i);
            if (r_ff.rd && hit && {r_ff.ra[3:0], bitv} == `MAM_REG_EXP) begin
              nxt_r.pd_fault = 1'b0;
            end
          end
        end
        S_TA: begin
          nxt_r.cnt = 4'h1;
          if (r_ff.cnt == 4'h0) begin
            if (r_ff.rd && hit) begin
              nxt_r.dio_oe = 1'b1;
              nxt_r.dio_o  = 1'b0;
            end else if (!r_ff.rd && !bitv) begin
              nxt_r.st = S_PRE;
            end
          end else begin
            nxt_r.cnt = 4'h0;
            nxt_r.st  = S_DAT;
            if (r_ff.rd) begin
              nxt_r.dio_o = r_ff.sh[15];
              nxt_r.sh    = {r_ff.sh[14:0], 1'b0};
            end else if (bitv) begin
              nxt_r.st = S_PRE;
            end
          end
        end
        S_DAT: begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
          if (r_ff.rd) begin
            nxt_r.dio_o = r_ff.sh[15];
            nxt_r.sh    = {r_ff.sh[14:0], 1'b0};
          end else begin
            nxt_r.sh = d;
          end
          if (r_ff.cnt == `MAM_LAST_BIT) begin
            nxt_r.dio_oe = 1'b0;
            nxt_r.dio_o  = 1'b0;
            nxt_r.st     = S_IDLE;
            if (!r_ff.rd && hit) begin
              case (r_ff.ra)
                `MAM_REG_CTRL: begin
                  nxt_r.spd_c   = d[`MAM_CTL_SPEED];
                  nxt_r.negen_c = d[`MAM_CTL_NEGEN];
                  nxt_r.dpx_c   = d[`MAM_CTL_DUPLEX];
                  if (d[`MAM_CTL_RESTART] || (d[`MAM_CTL_NEGEN] && !r_ff.negen_c)) begin
                    nxt_r.restart = 1'b1;
                    nxt_r.done    = 1'b0;
                  end
                end
                `MAM_REG_ADV: nxt_r.adv = {d[15:5], `MAM_ADV_SEL};
                default: ;
              endcase
            end
          end
        end
        default: nxt_r.st = S_PRE;
      endcase
    end

    // Events from the negotiation engine come last so a set beats a clear.
    if (neg_page_rx_i && r_ff.negen_c) begin
      nxt_r.lp      = neg_page_i;
      nxt_r.lp_able = 1'b1;
      nxt_r.done    = 1'b1;
    end
    if (pd_event_i && r_ff.negen_c) begin
      if (pd_link10_i ^ pd_link100_i) begin
        nxt_r.lp      = pd_link100_i ? `MAM_LP_PD100 : `MAM_LP_PD10;
        nxt_r.lp_able = 1'b0;
        nxt_r.done    = 1'b1;
      end else begin
        nxt_r.pd_fault = 1'b1;
      end
    end

    // Forced bits steer the mode only while negotiation is off.
    if (r_ff.negen_c) begin
      nxt_r.spd_o = r_ff.done & res_spd;
      nxt_r.dpx_o = r_ff.done & res_fdx;
    end else begin
      nxt_r.spd_o = r_ff.spd_c;
      nxt_r.dpx_o = r_ff.dpx_c;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r_ff     <= '0;
      r_ff.st  <= S_PRE;
      r_ff.adv <= {11'h00F, `MAM_ADV_SEL};
      // Synchronisers start at the idle-high line level, so no false clock edge follows reset.
      r_ff.mdc_s1 <= 1'b1;
      r_ff.mdc_s2 <= 1'b1;
      r_ff.mdc_d  <= 1'b1;
      r_ff.dio_s1 <= 1'b1;
      r_ff.dio_s2 <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign mdio_o         = r_ff.dio_o;
  assign mdio_oe_o      = r_ff.dio_oe;
  assign adv_word_o     = r_ff.adv;
  assign neg_enable_o   = r_ff.negen_c;
  assign neg_restart_o  = r_ff.restart;
  assign neg_complete_o = r_ff.done;
  assign speed100_o     = r_ff.spd_o;
  assign full_dpx_o     = r_ff.dpx_o;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_pre_quiet: assert property ((r_ff.st == S_PRE) |-> !mdio_oe_o)
    else $error("Port drives before sync.");
  a_pre_sync: assert property ((r_ff.st == S_PRE && rise && bitv && r_ff.ones == 6'h1F)
    |=> (r_ff.st == S_IDLE))
    else $error("Sync not taken after 32 ones.");
  a_bad_start: assert property ((r_ff.st == S_ST && rise && !bitv) |=> (r_ff.st == S_PRE))
    else $error("Bad start kept sync.");
  a_bad_op: assert property ((r_ff.st == S_OP && rise && r_ff.cnt == 4'h1 && bitv == r_ff.op_b)
    |=> (r_ff.st == S_PRE))
    else $error("Bad opcode kept sync.");
  a_ta_zero: assert property ((r_ff.st == S_TA && rise && r_ff.cnt == 4'h0 && r_ff.rd && hit)
    |=> (mdio_oe_o && !mdio_o))
    else $error("Turnaround zero missing.");
  a_ta_float: assert property ((r_ff.st == S_TA && r_ff.cnt == 4'h0) |-> !mdio_oe_o)
    else $error("Line driven in first turnaround.");
  a_pd_fault: assert property ((pd_event_i && r_ff.negen_c && pd_link10_i == pd_link100_i)
    |=> r_ff.pd_fault)
    else $error("Detect fault not set.");
  a_pd_load: assert property ((pd_event_i && r_ff.negen_c && pd_link100_i && !pd_link10_i)
    |=> (r_ff.lp == 16'h0081 && !r_ff.lp_able && r_ff.done))
    else $error("Detect pattern wrong.");
  a_restart_go: assert property ((r_ff.st == S_DAT && rise && r_ff.cnt == 4'hF && !r_ff.rd
    && hit && r_ff.ra == 5'h00 && d[9] && !neg_page_rx_i && !pd_event_i)
    |=> (neg_restart_o && !neg_complete_o) ##1 !neg_restart_o)
    else $error("Restart not pulsed.");
  a_forced_mode: assert property ((!r_ff.negen_c && $stable(r_ff.spd_c) && $stable(r_ff.negen_c))
    |=> (speed100_o == $past(r_ff.spd_c)))
    else $error("Forced speed not applied.");
  a_strap_adv: assert property ((r_ff.init_cnt == 2'h2) |=> (adv_word_o[8:5]
    == strap_adv($past(r_ff.strap_s2))))
    else $error("Strap advertisement wrong.");

  c_read_done: cover property (r_ff.st == S_DAT && r_ff.rd && rise && r_ff.cnt == 4'hF && hit);
  c_write_done: cover property (r_ff.st == S_DAT && !r_ff.rd && rise && r_ff.cnt == 4'hF && hit);
  c_pd_done: cover property (pd_event_i && r_ff.negen_c && (pd_link10_i ^ pd_link100_i));
  c_resync: cover property (r_ff.st == S_OP ##1 r_ff.st == S_PRE);
endmodule
`default_nettype wire

/* verif/mam_sta.sv */
// Station manager model: clocks frames and preambles onto the management line.
// Assumes the bench resolves the line with a pull-up and feeds it back on line_i.
`timescale 1ns/1ps
`default_nettype none
module mam_sta (
  // Clock.
  input  wire logic clk_i,
  // Management line.
  input  wire logic line_i,
  output logic      mdc_o,
  output logic      drv_o,
  output logic      dat_o
);
  // ==========================================================
  // Bit and frame tasks
  initial begin
    mdc_o = 1'b1;
    drv_o = 1'b0;
    dat_o = 1'b1;
  end

  // Eight system clocks a bit give 80 ns; the line is read as the clock rises.
  task automatic bit_x(input logic d, input logic en, output logic s);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    drv_o <= en;
    dat_o <= d;
    repeat (4) @(posedge clk_i);
    s = line_i;
    mdc_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  // The line is released so that the pull-up alone supplies the ones.
  task automatic preamble();
    logic s;
    repeat (32) bit_x(1'b1, 1'b0, s);
  endtask

  // The clock stands still high after a frame, and the line is let go.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [1:0] ta, input logic [15:0] wd, output logic [31:0] seen);
    logic [31:0] w;
    logic        s;
    w = {2'b01, op, pa, ra, ta, wd};
    bit_x(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_x(w[i], !(op == 2'b10 && i < 18), s);
      seen[i] = s;
    end
    repeat (4) @(posedge clk_i);
    drv_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the management port, driven through the station model.
// Assumes the design files and verif/mam_sta.sv are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        mdc, drv, dat, line, mo, moe;
  logic        en_s = 1'b1, hi_s = 1'b1, lo_s = 1'b1;
  logic        lnk = 1'b0, prx = 1'b0, pde = 1'b0, p10 = 1'b0, p100 = 1'b0;
  logic [15:0] page = 16'h0000;
  logic [15:0] adv_w;
  logic        n_en, n_rs, n_cp, spd, fdx;
  logic [31:0] sn;
  int          err_total = 0;
  int          check_count = 0;
  int          rs_cnt = 0;

  // ==========================================================
  // Line, clock and instances
  assign line = moe ? mo : (drv ? dat : 1'b1);
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (n_rs === 1'b1) rs_cnt++;

  mam_sta sta (.clk_i(clk_i), .line_i(line), .mdc_o(mdc), .drv_o(drv), .dat_o(dat));
  mam_mgmt DUT (.clk_i(clk_i), .srst_i(srst_i), .mdc_i(mdc), .mdio_i(line), .mdio_o(mo),
    .mdio_oe_o(moe), .negotiation_enable_strap_i(en_s), .mode_strap_high_i(hi_s),
    .mode_strap_low_i(lo_s), .link_up_i(lnk), .neg_page_rx_i(prx), .neg_page_i(page),
    .pd_event_i(pde), .pd_link10_i(p10), .pd_link100_i(p100), .adv_word_o(adv_w),
    .neg_enable_o(n_en), .neg_restart_o(n_rs), .neg_complete_o(n_cp),
    .speed100_o(spd), .full_dpx_o(fdx));

  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdc(input logic [4:0] ra, input logic [15:0] e, input string n);
    sta.frame(2'b10, 5'h01, ra, 2'b11, 16'hFFFF, sn);
    chk(n, e, sn[15:0]);
  endtask

  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [1:0] ta,
                    input logic [15:0] d);
    sta.frame(2'b01, pa, ra, ta, d, sn);
  endtask

  // Straps are held through reset and well past the load point.
  task automatic do_reset(input logic [2:0] k);
    @(posedge clk_i);
    srst_i <= 1'b1;
    {en_s, hi_s, lo_s} <= k;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask

  task automatic ev(input logic rx, input logic l10, input logic l100);
    @(posedge clk_i);
    prx <= rx;
    pde <= !rx;
    p10 <= l10;
    p100 <= l100;
    @(posedge clk_i);
    prx <= 1'b0;
    pde <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_straps();
    logic [3:0] en_t [4] = '{4'h3, 4'hC, 4'h5, 4'hF};
    logic [3:0] a;
    for (int k = 0; k < 8; k++) begin
      do_reset(k[2:0]);
      a = k[2] ? en_t[k[1:0]] : 4'h1 << k[1:0];
      chk("adv_word", {7'h00, a, 5'h01}, adv_w);
      chk("neg_enable", {15'h0000, k[2]}, {15'h0000, n_en});
      chk("mode", k[2] ? 16'h0000 : {14'h0000, k[1:0]}, {14'h0000, spd, fdx});
    end
  endtask

  task automatic t_sync();
    rdc(5'h01, 16'hFFFF, "unsynced_read");
    sta.preamble();
    rdc(5'h01, 16'h7849, "status");
    chk("turnaround", 16'h0002, {14'h0000, sn[17:16]});
    lnk <= 1'b1;
    rdc(5'h01, 16'h784D, "status_no_preamble");
  endtask

  task automatic t_regs();
    wr(5'h01, 5'h04, 2'b10, 16'h0061);
    chk("adv_word", 16'h0061, adv_w);
    rdc(5'h04, 16'h0061, "adv_read");
    wr(5'h02, 5'h04, 2'b10, 16'h01E1);
    sta.frame(2'b10, 5'h02, 5'h04, 2'b11, 16'hFFFF, sn);
    chk("other_phy", 16'hFFFF, sn[15:0]);
    rdc(5'h04, 16'h0061, "adv_kept");
    rdc(5'h1F, 16'h0000, "unmapped");
  endtask

  // A start pattern of two zeros is sent bit by bit, since frames always open with 01.
  task automatic t_bad();
    sta.frame(2'b11, 5'h01, 5'h01, 2'b10, 16'h0000, sn);
    rdc(5'h01, 16'hFFFF, "after_bad_opcode");
    sta.preamble();
    sta.bit_x(1'b0, 1'b1, sn[0]);
    sta.bit_x(1'b0, 1'b1, sn[0]);
    rdc(5'h01, 16'hFFFF, "after_bad_start");
    sta.preamble();
    wr(5'h01, 5'h04, 2'b00, 16'h0000);
    rdc(5'h04, 16'hFFFF, "after_bad_ta");
    sta.preamble();
    rdc(5'h04, 16'h0061, "adv_after_bad_ta");
  endtask

  task automatic t_neg();
    page <= 16'h01E1;
    ev(1'b1, 1'b0, 1'b0);
    chk("complete", 16'h0001, {15'h0000, n_cp});
    chk("neg_mode", 16'h0001, {14'h0000, spd, fdx});
    rdc(5'h05, 16'h01E1, "partner");
  endtask

  task automatic t_restart();
    wr(5'h01, 5'h04, 2'b10, 16'h01E1);
    rs_cnt = 0;
    wr(5'h01, 5'h00, 2'b10, 16'h1200);
    chk("restart_pulses", 16'h0001, rs_cnt[15:0]);
    chk("complete_cleared", 16'h0000, {15'h0000, n_cp});
    rdc(5'h00, 16'h1000, "control");
  endtask

  task automatic t_pd();
    ev(1'b0, 1'b0, 1'b1);
    rdc(5'h05, 16'h0081, "pd_partner");
    rdc(5'h01, 16'h786D, "pd_status");
    chk("pd_mode", 16'h0002, {14'h0000, spd, fdx});
    rdc(5'h10, 16'h0011, "summary");
    rdc(5'h06, 16'h0000, "expansion");
    chk("partner_able", 16'h0000, {15'h0000, sn[0]});
    ev(1'b0, 1'b1, 1'b1);
    sta.frame(2'b10, 5'h01, 5'h06, 2'b11, 16'hFFFF, sn);
    chk("pd_fault", 16'h0001, {15'h0000, sn[4]});
    rdc(5'h06, 16'h0000, "pd_fault_cleared");
    ev(1'b0, 1'b0, 1'b0);
    rdc(5'h06, 16'h0010, "pd_no_link");
  endtask

  task automatic t_force();
    do_reset(3'b000);
    sta.preamble();
    wr(5'h01, 5'h00, 2'b10, 16'h2100);
    chk("forced_mode", 16'h0003, {14'h0000, spd, fdx});
    wr(5'h01, 5'h00, 2'b10, 16'h3100);
    chk("bits_ignored", 16'h0000, {14'h0000, spd, fdx});
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_straps();
    t_sync();
    t_regs();
    t_bad();
    t_neg();
    t_restart();
    t_pd();
    t_force();
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
